// File: mdi_map.svh
`ifndef MDI_MAP_SVH
`define MDI_MAP_SVH
// ==========================================================
// timing
`define MDI_CLK_KHZ      40000
`define MDI_ILIM_MS      275
`define MDI_PWRUP_US     60
`define MDI_PWRUP_CYC    12'((`MDI_PWRUP_US * `MDI_CLK_KHZ + 999) / 1000)
`define MDI_SCL_QTR_CYC  10'h064
`define MDI_SYNC_FILL    2'h3
// ==========================================================
// link addressing and sub addresses
`define MDI_ADDR_BASE    7'h60
`define MDI_PIN_RADIX    7'h03
`define MDI_PIN_LOW      2'h0
`define MDI_PIN_OPEN     2'h1
`define MDI_PIN_HIGH     2'h2
`define MDI_SUB_CTRL     8'h00
`define MDI_SUB_FAULT    8'h01
`define MDI_REG_RST      8'h00
`define MDI_BIT_LAST     4'h8
`define MDI_TX_LAST      4'h7
// ==========================================================
// register fields
`define MDI_CTRL_DAC     7:2
`define MDI_CTRL_DIR_B   1
`define MDI_CTRL_DIR_A   0
`define MDI_FLT_CLR      7
`define MDI_FLT_ILIM     4
`define MDI_FLT_OT       3
`define MDI_FLT_UV       2
`define MDI_FLT_SC       1
`define MDI_FLT_SUM      0
// ==========================================================
// commanded voltage in millivolts
`define MDI_VREF_MV      1285
`define MDI_DAC_GAIN     4
`define MDI_DAC_SHIFT    6
// ==========================================================
// controller registers on apb
`define MDI_APB_CMD      12'h000
`define MDI_APB_STAT     12'h004
`define MDI_CMD_DATA     7:0
`define MDI_CMD_SUB      15:8
`define MDI_CMD_ADDR     22:16
`define MDI_CMD_OP       25:24
`define MDI_OP_WRITE     2'h0
`define MDI_OP_PTR       2'h1
`define MDI_OP_READ      2'h2
`define MDI_OP_RSVD      2'h3
`define MDI_STAT_BUSY    0
`define MDI_STAT_NACK    1
`define MDI_STAT_PWR_OK  2
`define MDI_STAT_RX      15:8
`endif

// File: mdi_pkg.sv
`default_nettype none
package mdi_pkg;
   // ==========================================================
   // states
   typedef enum logic [6:0] {
      DEV_IDLE  = 7'h01,
      DEV_ADDR  = 7'h02,
      DEV_AACK  = 7'h04,
      DEV_WDATA = 7'h08,
      DEV_WACK  = 7'h10,
      DEV_RDATA = 7'h20,
      DEV_RACK  = 7'h40
   } mdi_dev_st_t;

   typedef enum logic [3:0] {
      HST_IDLE  = 4'h1,
      HST_START = 4'h2,
      HST_XFER  = 4'h4,
      HST_STOP  = 4'h8
   } mdi_hst_st_t;

   // ==========================================================
   // whole state of each end
   typedef struct packed {
      mdi_dev_st_t  st;
      logic         scl_d;
      logic         sda_d;
      logic [7:0]   sh;
      logic [3:0]   cnt;
      logic         first;
      logic [7:0]   sub;
      logic [7:0]   ctrl;
      logic         ilim;
      logic         ot;
      logic         uv;
      logic         sc;
      logic [23:0]  lim_cnt;
      logic         oe;
      logic         cap_done;
      logic [1:0]   boot;
      logic [6:0]   my_addr;
      logic         out_a;
      logic         out_b;
      logic         out_en;
      logic         stby;
      logic         fault_n;
      logic [12:0]  vout;
   } mdi_dev_state_t;

   typedef struct packed {
      mdi_hst_st_t  st;
      logic [9:0]   div;
      logic [1:0]   ph;
      logic [3:0]   bitn;
      logic [1:0]   idx;
      logic [7:0]   sh;
      logic [25:0]  cmd;
      logic         nack;
      logic [7:0]   rx;
      logic         scl_lv;
      logic         sda_lv;
      logic [11:0]  pwr_cnt;
      logic         pwr_ok;
      logic [31:0]  prdata;
      logic         slverr;
   } mdi_hst_state_t;
endpackage
`default_nettype wire

// File: mdi_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mdi_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // ==========================================================
   // open-drain wires with pull-ups: any enabled low driver wins
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                 output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// File: mdi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mdi_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] d_out
);
   logic [W-1:0] meta_r;

   // ==========================================================
   // two-flop synchroniser, first stage feeds only the second
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= '0;
         d_out  <= '0;
      end
      else
      begin
         meta_r <= d_in;
         d_out  <= meta_r;
      end
   end
endmodule // mdi_sync
`default_nettype wire

// File: mdi_dev.sv
// What this block does
// - device is slave only, never drives clock
// - transfer opens with start condition
// - msb-first address byte, acknowledge on match
// - address pins sampled once after power-up
// - address is base plus pin code
// - general call address never acknowledged
// - write data bytes acknowledged, first is subaddress
// - read returns last selected register, then ack
// - only complete acknowledged bytes update registers
// - transfer closes with stop condition
// - master waits 60 us before first start
// - control at 0x00, fault at 0x01, reset zero
// - control holds dac code and direction bits
// - fault register bit layout
// - writing clear bit resets fault flags
// - summary flag set while any fault present
// - each source flag set by own cause
// - direction bits decode bridge outputs
// - commanded voltage from dac code
// - persistent current limit flags fault
// - short circuit disables bridge until clear
`timescale 1ns/1ps
`default_nettype none
`include "mdi_map.svh"
module mdi_dev #(
   parameter int unsigned ILIM_CYC = `MDI_ILIM_MS * `MDI_CLK_KHZ
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   mdi_if.dev               link,
   input  wire logic [1:0]  addr_sel_lo_pin,
   input  wire logic [1:0]  addr_sel_hi_pin,
   input  wire logic        ilim_active,
   input  wire logic        over_temp,
   input  wire logic        undervoltage,
   input  wire logic        short_circuit,
   output logic      [5:0]  dac_voltage_code,
   output logic             bridge_dir_a,
   output logic             bridge_dir_b,
   output logic      [12:0] vout_mv,
   output logic             out_a_high,
   output logic             out_b_high,
   output logic             out_enable,
   output logic             standby,
   output logic             fault_out_low,
   output logic      [6:0]  dev_addr
);
   localparam logic [23:0] LIM_TOP = 24'(ILIM_CYC - 1);

   mdi_pkg::mdi_dev_state_t r;
   mdi_pkg::mdi_dev_state_t n;
   logic [9:0]              sy;
   logic                    scl_s;
   logic                    sda_s;
   logic [1:0]              lo_s;
   logic [1:0]              hi_s;
   logic                    ilim_s;
   logic                    ot_s;
   logic                    uv_s;
   logic                    sc_s;
   logic                    rise;
   logic                    fall;
   logic                    start;
   logic                    stop;
   logic                    live;

   // ==========================================================
   // functions
   // pin code 3*hi + lo on top of the fixed base
   function automatic logic [6:0] addr_of(input logic [1:0] hi, input logic [1:0] lo);
      return `MDI_ADDR_BASE + 7'(hi) * `MDI_PIN_RADIX + 7'(lo);
   endfunction

   function automatic logic [7:0] fault_word(input mdi_pkg::mdi_dev_state_t s,
                                             input logic any);
      logic [7:0] w;
      w = `MDI_REG_RST;                // clear and unused read zero
      w[`MDI_FLT_ILIM] = s.ilim;
      w[`MDI_FLT_OT]   = s.ot;
      w[`MDI_FLT_UV]   = s.uv;
      w[`MDI_FLT_SC]   = s.sc;
      w[`MDI_FLT_SUM]  = any;
      return w;
   endfunction

   function automatic logic [7:0] reg_read(input mdi_pkg::mdi_dev_state_t s,
                                           input logic any);
      if (s.sub == `MDI_SUB_CTRL)
         return s.ctrl;
      else if (s.sub == `MDI_SUB_FAULT)
         return fault_word(s, any);
      else
         return `MDI_REG_RST;
   endfunction

   function automatic logic [12:0] volt_of(input logic [5:0] code);
      return 13'((`MDI_DAC_GAIN * `MDI_VREF_MV * (32'(code) + 1)) >> `MDI_DAC_SHIFT);
   endfunction

   // ==========================================================
   // everything from pins crosses in here
   mdi_sync #(.W(10)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d_in     ({link.scl, link.sda, addr_sel_lo_pin, addr_sel_hi_pin,
                  ilim_active, over_temp, undervoltage, short_circuit}),
      .d_out    (sy)
   );
   assign {scl_s, sda_s, lo_s, hi_s, ilim_s, ot_s, uv_s, sc_s} = sy;

   // bus events from the synchronised levels
   assign rise  = scl_s & ~r.scl_d;
   assign fall  = ~scl_s & r.scl_d;
   assign start = scl_s & r.scl_d & r.sda_d & ~sda_s;
   assign stop  = scl_s & r.scl_d & ~r.sda_d & sda_s;
   assign live  = r.ilim | r.ot | r.uv | r.sc | ot_s | uv_s | sc_s;

   // ==========================================================
   // next state
   always_comb
   begin
      logic       clr;
      logic       dir_eq;
      logic       off;
      clr    = 1'b0;
      dir_eq = 1'b0;
      off    = 1'b0;
      n       = r;
      n.scl_d = scl_s;
      n.sda_d = sda_s;

      // strap capture once the synchroniser has filled; later pin moves ignored
      if (!r.cap_done)
      begin
         n.boot = r.boot + 2'h1;
         if (r.boot == `MDI_SYNC_FILL)
         begin
            n.my_addr  = addr_of(hi_s, lo_s);
            n.cap_done = 1'b1;
         end
      end

      // link engine: start or stop abandon any partial byte
      if (start)
      begin
         n.st  = mdi_pkg::DEV_ADDR;
         n.cnt = 4'h0;
         n.oe  = 1'b0;
      end
      else if (stop)
      begin
         n.st = mdi_pkg::DEV_IDLE;
         n.oe = 1'b0;
      end
      else
      begin
         unique case (r.st)
            mdi_pkg::DEV_IDLE:
            begin
            end
            mdi_pkg::DEV_ADDR:
            begin
               if (rise)
               begin
                  n.sh  = {r.sh[6:0], sda_s};
                  n.cnt = r.cnt + 4'h1;
               end
               else if (fall && r.cnt == `MDI_BIT_LAST)
               begin
                  // general call can never equal the pin address
                  if (r.cap_done && r.sh[7:1] == r.my_addr)
                  begin
                     n.st = mdi_pkg::DEV_AACK;
                     n.oe = 1'b1;
                  end
                  else
                     n.st = mdi_pkg::DEV_IDLE;
               end
            end
            mdi_pkg::DEV_AACK:
            begin
               if (fall)
               begin
                  n.cnt = 4'h0;
                  if (r.sh[0])
                  begin
                     n.st = mdi_pkg::DEV_RDATA;
                     n.sh = reg_read(r, live);
                     n.oe = ~n.sh[7];
                  end
                  else
                  begin
                     n.st    = mdi_pkg::DEV_WDATA;
                     n.oe    = 1'b0;
                     n.first = 1'b1;
                  end
               end
            end
            mdi_pkg::DEV_WDATA:
            begin
               if (rise)
               begin
                  n.sh  = {r.sh[6:0], sda_s};
                  n.cnt = r.cnt + 4'h1;
               end
               else if (fall && r.cnt == `MDI_BIT_LAST)
               begin
                  n.st = mdi_pkg::DEV_WACK;
                  n.oe = 1'b1;
               end
            end
            mdi_pkg::DEV_WACK:
            begin
               // byte lands only at the end of its own ack clock
               if (fall)
               begin
                  n.st    = mdi_pkg::DEV_WDATA;
                  n.oe    = 1'b0;
                  n.cnt   = 4'h0;
                  n.first = 1'b0;
                  if (r.first)
                     n.sub = r.sh;
                  else if (r.sub == `MDI_SUB_CTRL)
                     n.ctrl = r.sh;
                  else if (r.sub == `MDI_SUB_FAULT)
                     clr = r.sh[`MDI_FLT_CLR];
               end
            end
            mdi_pkg::DEV_RDATA:
            begin
               if (fall)
               begin
                  if (r.cnt == `MDI_TX_LAST)
                  begin
                     n.st = mdi_pkg::DEV_RACK;
                     n.oe = 1'b0;
                  end
                  else
                  begin
                     n.sh  = {r.sh[6:0], 1'b0};
                     n.oe  = ~r.sh[6];
                     n.cnt = r.cnt + 4'h1;
                  end
               end
            end
            mdi_pkg::DEV_RACK:
            begin
               // master ack keeps the register streaming, nack ends it
               if (rise)
                  n.sh[0] = sda_s;
               else if (fall)
               begin
                  n.cnt = 4'h0;
                  if (!r.sh[0])
                  begin
                     n.st = mdi_pkg::DEV_RDATA;
                     n.sh = reg_read(r, live);
                     n.oe = ~n.sh[7];
                  end
                  else
                     n.st = mdi_pkg::DEV_IDLE;
               end
            end
         endcase
      end

      // persistence counter for current limiting
      if (!ilim_s)
         n.lim_cnt = 24'h000000;
      else if (r.lim_cnt != LIM_TOP)
         n.lim_cnt = r.lim_cnt + 24'h000001;

      // sticky flags: a cause in the clear cycle still sets
      dir_eq = n.ctrl[`MDI_CTRL_DIR_A] == n.ctrl[`MDI_CTRL_DIR_B];
      n.ilim = (ilim_s & (r.lim_cnt == LIM_TOP)) | (r.ilim & ~(clr | dir_eq));
      n.ot   = ot_s | (r.ot & ~clr);
      n.uv   = uv_s | (r.uv & ~clr);
      n.sc   = sc_s | (r.sc & ~clr);
      n.fault_n = ~(n.ilim | n.ot | n.uv | n.sc | ot_s | uv_s | sc_s);

      // bridge: out1 follows dir a, out2 dir b while enabled
      off      = n.sc | ot_s | uv_s;
      n.out_a  = n.ctrl[`MDI_CTRL_DIR_A];
      n.out_b  = n.ctrl[`MDI_CTRL_DIR_B];
      n.stby   = ~(n.out_a | n.out_b);
      n.out_en = (n.out_a | n.out_b) & ~off;
      n.vout   = volt_of(n.ctrl[`MDI_CTRL_DAC]);
   end

   // ==========================================================
   // state register
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r         <= '0;
         r.st      <= mdi_pkg::DEV_IDLE;
         r.scl_d   <= 1'b1;
         r.sda_d   <= 1'b1;
         r.ctrl    <= `MDI_REG_RST;
         r.stby    <= 1'b1;
         r.fault_n <= 1'b1;
         r.vout    <= volt_of(6'h00);
      end
      else
         r <= n;
   end

   // ==========================================================
   // outputs; the clock pin is never driven
   assign link.dev_sda_o   = 1'b0;
   assign link.dev_sda_oe  = r.oe;
   assign dac_voltage_code = r.ctrl[`MDI_CTRL_DAC];
   assign bridge_dir_a     = r.ctrl[`MDI_CTRL_DIR_A];
   assign bridge_dir_b     = r.ctrl[`MDI_CTRL_DIR_B];
   assign vout_mv          = r.vout;
   assign out_a_high       = r.out_a;
   assign out_b_high       = r.out_b;
   assign out_enable       = r.out_en;
   assign standby          = r.stby;
   assign fault_out_low    = r.fault_n;
   assign dev_addr         = r.my_addr;
endmodule // mdi_dev
`default_nettype wire

// File: mdi_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdi_map.svh"
module mdi_host (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   mdi_if.host              link
);
   mdi_pkg::mdi_hst_state_t r;
   mdi_pkg::mdi_hst_state_t n;
   logic                    scl_s;
   logic                    sda_s;

   // byte sequence: address with direction, subaddress, data
   function automatic logic [7:0] byte_of(input logic [25:0] c, input logic [1:0] i);
      if (i == 2'h0)
         return {c[`MDI_CMD_ADDR], c[`MDI_CMD_OP] == `MDI_OP_READ};
      else if (i == 2'h1)
         return c[`MDI_CMD_SUB];
      else
         return c[`MDI_CMD_DATA];
   endfunction

   mdi_sync #(.W(2)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d_in     ({link.scl, link.sda}),
      .d_out    ({scl_s, sda_s})
   );

   // ==========================================================
   // next state
   always_comb
   begin
      logic        tick;
      logic        tx;
      logic        idle;
      logic        sel_c;
      logic        sel_s;
      logic [1:0]  last;
      logic [31:0] stat;
      tick  = r.div == `MDI_SCL_QTR_CYC - 10'h001;
      idle  = r.st == mdi_pkg::HST_IDLE;
      tx    = ~(r.cmd[`MDI_CMD_OP] == `MDI_OP_READ && r.idx == 2'h1);
      last  = (r.cmd[`MDI_CMD_OP] == `MDI_OP_WRITE) ? 2'h2 : 2'h1;
      sel_c = paddr == `MDI_APB_CMD;
      sel_s = paddr == `MDI_APB_STAT;
      stat  = 32'h00000000;
      stat[`MDI_STAT_BUSY]   = ~idle;
      stat[`MDI_STAT_NACK]   = r.nack;
      stat[`MDI_STAT_PWR_OK] = r.pwr_ok;
      stat[`MDI_STAT_RX]     = r.rx;
      n     = r;
      n.div = tick ? 10'h000 : r.div + 10'h001;

      // no start until the device has had its power-up time
      if (!r.pwr_ok)
      begin
         n.pwr_cnt = r.pwr_cnt + 12'h001;
         n.pwr_ok  = r.pwr_cnt == `MDI_PWRUP_CYC - 12'h001;
      end

      // apb: answer prepared in setup, acted on in access
      if (psel && !penable)
      begin
         n.prdata = sel_s ? stat : (sel_c ? {6'h00, r.cmd} : 32'h00000000);
         n.slverr = ~(sel_c | sel_s) | (pwrite & sel_s) |
                    (pwrite & sel_c & (~idle | ~r.pwr_ok |
                     pwdata[`MDI_CMD_OP] == `MDI_OP_RSVD));
      end
      if (psel && penable && pwrite && sel_c && !r.slverr)
      begin
         n.cmd  = pwdata[25:0];
         n.st   = mdi_pkg::HST_START;
         n.ph   = 2'h0;
         n.div  = 10'h000;
         n.nack = 1'b0;
      end

      // link sequencer, four quarter phases per bit
      if (tick)
      begin
         n.ph = r.ph + 2'h1;
         unique case (r.st)
            mdi_pkg::HST_IDLE:
               n.ph = 2'h0;
            mdi_pkg::HST_START:
            begin
               if (r.ph == 2'h1)
                  n.sda_lv = 1'b0;
               else if (r.ph == 2'h2)
                  n.scl_lv = 1'b0;
               else if (r.ph == 2'h3)
               begin
                  n.st   = mdi_pkg::HST_XFER;
                  n.bitn = 4'h0;
                  n.idx  = 2'h0;
                  n.sh   = byte_of(r.cmd, 2'h0);
               end
            end
            mdi_pkg::HST_XFER:
            begin
               if (r.ph == 2'h0)
                  n.sda_lv = (tx && r.bitn != `MDI_BIT_LAST) ? r.sh[7] : 1'b1;
               else if (r.ph == 2'h1)
                  n.scl_lv = 1'b1;
               else if (r.ph == 2'h2)
               begin
                  // wait while the clock is held low by anyone
                  if (!scl_s)
                     n.ph = r.ph;
                  else if (r.bitn == `MDI_BIT_LAST)
                     n.nack = tx & sda_s;
                  else if (!tx)
                     n.rx = {r.rx[6:0], sda_s};
               end
               else
               begin
                  n.scl_lv = 1'b0;
                  if (r.bitn != `MDI_BIT_LAST)
                  begin
                     n.sh   = {r.sh[6:0], 1'b0};
                     n.bitn = r.bitn + 4'h1;
                  end
                  else if (r.nack || r.idx == last)
                     n.st = mdi_pkg::HST_STOP;
                  else
                  begin
                     n.idx  = r.idx + 2'h1;
                     n.sh   = byte_of(r.cmd, r.idx + 2'h1);
                     n.bitn = 4'h0;
                  end
               end
            end
            mdi_pkg::HST_STOP:
            begin
               if (r.ph == 2'h0)
                  n.sda_lv = 1'b0;
               else if (r.ph == 2'h1)
                  n.scl_lv = 1'b1;
               else if (r.ph == 2'h2)
                  n.sda_lv = 1'b1;
               else
                  n.st = mdi_pkg::HST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r        <= '0;
         r.st     <= mdi_pkg::HST_IDLE;
         r.scl_lv <= 1'b1;
         r.sda_lv <= 1'b1;
      end
      else
         r <= n;
   end

   // zero-wait slave; lines are open drain
   assign pready           = 1'b1;
   assign prdata           = r.prdata;
   assign pslverr          = r.slverr;
   assign link.host_scl_o  = 1'b0;
   assign link.host_scl_oe = ~r.scl_lv;
   assign link.host_sda_o  = 1'b0;
   assign link.host_sda_oe = ~r.sda_lv;
endmodule // mdi_host
`default_nettype wire

// File: mdi_link_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// link checker
module mdi_link_props (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic host_scl_o,
   input wire logic host_scl_oe,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // wire rules
   a_scl_host_only: assert property ($fell(scl) |-> $rose(host_scl_oe))
      else $error("scl pulled low without host");
   a_scl_low_bound: assert property ($fell(scl) |-> ##[1:450] scl)
      else $error("scl held low too long");
   a_open_drain: assert property (!(host_scl_oe & host_scl_o) && !(dev_sda_oe & dev_sda_o))
      else $error("line driven high");
   a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
      else $error("device moved sda while scl high");
   a_no_contend: assert property (dev_sda_oe && scl |-> !host_sda_oe)
      else $error("both ends pull sda while scl high");
   a_start_form: assert property ($rose(host_sda_oe) && scl |-> ##[1:120] !scl)
      else $error("start not followed by clock");
   a_stop_idle: assert property ($rose(sda) && scl && $past(scl) |-> scl [*8])
      else $error("bus not idle after stop");
   a_ack_hold: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
      else $error("device pull too short");
   // main scenarios seen
   c_ack: cover property ($rose(dev_sda_oe));
   c_start: cover property ($fell(sda) && scl);
   c_stop: cover property ($rose(sda) && scl);
endmodule // mdi_link_props
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdi_map.svh"
module tb_top;
   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic        ot, sc, oen, stby, dir_a, dir_b, fault_low_n;
   logic [1:0]  lo_pin, hi_pin;
   logic [5:0]  dac;
   logic [6:0]  dev_addr;
   logic [11:0] paddr;
   logic [12:0] vout;
   logic [31:0] pwdata, prdata, q;
   int          errors, n_checks, n;
   mdi_if link_if ();
   mdi_dev #(.ILIM_CYC(64)) mdi_dev_i (.core_clk, .rst_n, .link(link_if.dev),
      .addr_sel_lo_pin(lo_pin), .addr_sel_hi_pin(hi_pin), .ilim_active(1'h0),
      .over_temp(ot), .undervoltage(1'h0), .short_circuit(sc), .dac_voltage_code(dac),
      .bridge_dir_a(dir_a), .bridge_dir_b(dir_b), .vout_mv(vout), .out_a_high(),
      .out_b_high(), .out_enable(oen), .standby(stby), .fault_out_low(fault_low_n), .dev_addr);
   mdi_host mdi_host_i (.core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .link(link_if.host));
   mdi_link_props mdi_link_props_i (.core_clk, .rst_n, .host_scl_o(link_if.host_scl_o),
      .host_scl_oe(link_if.host_scl_oe), .host_sda_oe(link_if.host_sda_oe),
      .dev_sda_o(link_if.dev_sda_o), .dev_sda_oe(link_if.dev_sda_oe),
      .scl(link_if.scl), .sda(link_if.sda));
   // ==========================================================
   // clock
   initial
   begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end
   // ==========================================================
   // tasks
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // one apb transfer; waits for pready, never assumes a count
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge core_clk);
         if (pready === 1'h1) break;
      end
      q = prdata; e = pslverr; psel <= 1'h0; penable <= 1'h0;
      if (k == 50) begin errors++; print_verdict(); end
   endtask
   // launch a link command and poll busy under a bound
   task automatic cmd(input logic [1:0] op, input logic [6:0] ad, input logic [7:0] sb,
                      input logic [7:0] dt);
      apb(1'h1, `MDI_APB_CMD, {6'h00, op, 1'h0, ad, sb, dt});
      for (n = 0; n < 6000; n++)
      begin
         apb(1'h0, `MDI_APB_STAT, 32'h0);
         if (q[`MDI_STAT_BUSY] === 1'h0) break;
      end
      if (n == 6000) begin errors++; print_verdict(); end
   endtask
   // ==========================================================
   // main sequence
   initial
   begin
      rst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h0;
      pwdata = 32'h0; {ot, sc} = 2'h0; lo_pin = `MDI_PIN_OPEN; hi_pin = `MDI_PIN_HIGH;
      errors = 0; n_checks = 0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'h1;
      repeat (8) @(posedge core_clk);
      lo_pin <= `MDI_PIN_HIGH; // late pin change must not move the address
      chk("dev_addr", 32'h67, dev_addr);
      apb(1'h1, `MDI_APB_CMD, 32'h0067_0000); chk("early cmd", 32'h1, e);
      apb(1'h0, 12'h008, 32'h0); chk("unmapped", 32'h1, e);
      repeat (2400) @(posedge core_clk);
      chk("dev_addr held", 32'h67, dev_addr);
      apb(1'h1, `MDI_APB_CMD, 32'h0367_0000); chk("rsvd op", 32'h1, e);
      cmd(`MDI_OP_WRITE, 7'h67, `MDI_SUB_CTRL, 8'hB6);
      chk("write nack", 32'h0, q[`MDI_STAT_NACK]);
      chk("dac", 32'h2D, dac);
      chk("dirs", 32'h2, {dir_b, dir_a});
      chk("vout", 32'hE6E, vout);
      chk("standby", 32'h0, stby);
      chk("bridge on", 32'h1, oen);
      cmd(`MDI_OP_READ, 7'h67, `MDI_SUB_CTRL, 8'h00);
      chk("ctrl read", 32'hB6, q[`MDI_STAT_RX]);
      // general call and a foreign address: refused, register untouched
      cmd(`MDI_OP_WRITE, 7'h00, `MDI_SUB_CTRL, 8'h00);
      chk("gcall nack", 32'h1, q[`MDI_STAT_NACK]);
      cmd(`MDI_OP_WRITE, 7'h60, `MDI_SUB_CTRL, 8'h00);
      chk("other nack", 32'h1, q[`MDI_STAT_NACK]);
      chk("dac kept", 32'h2D, dac);
      {ot, sc} <= 2'h3;
      repeat (8) @(posedge core_clk);
      {ot, sc} <= 2'h0;
      repeat (4) @(posedge core_clk);
      chk("fault pin", 32'h0, fault_low_n);
      chk("bridge off", 32'h0, oen);
      cmd(`MDI_OP_PTR, 7'h67, `MDI_SUB_FAULT, 8'h00);
      cmd(`MDI_OP_READ, 7'h67, `MDI_SUB_FAULT, 8'h00);
      chk("fault read", 32'h0B, q[`MDI_STAT_RX]);
      cmd(`MDI_OP_WRITE, 7'h67, `MDI_SUB_FAULT, 8'hFE);
      cmd(`MDI_OP_READ, 7'h67, `MDI_SUB_FAULT, 8'h00);
      chk("fault clear", 32'h00, q[`MDI_STAT_RX]);
      chk("bridge back", 32'h1, oen);
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
